/* File: testbench/hbp_host_model.sv */
`timescale 1ns/10ps
module hbp_host_model (
    // clock
    input  wire logic clk,
    // host pins
    output logic       conv_sel,
    output logic       strobe,
    output logic [6:0] pins,
    output logic       dack_a_n,
    output logic       dack_b_n,
    output logic       access
);
    // idle host: separate strobes, strobe parked high, no dma
    initial begin
        conv_sel = 1'b0;
        strobe   = 1'b1;
        pins     = 7'h00;
        dack_a_n = 1'b1;
        dack_b_n = 1'b1;
        access   = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // 16-bit host wires d[7:1], so registers look doubled
    task automatic mux_latch(input logic [7:0] byte_addr);
        pins   = byte_addr[7:1];
        strobe = 1'b1;
        cyc(3);
        strobe = 1'b0;
        cyc(4);
        pins   = ~byte_addr[7:1];
    endtask : mux_latch
    // strobe parked high means plain address pins
    task automatic direct(input logic [6:0] a);
        strobe = 1'b1;
        pins   = a;
        cyc(3);
    endtask : direct
    task automatic mode(input logic c, input logic s);
        conv_sel = c;
        strobe   = s;
        cyc(4);
    endtask : mode
    task automatic dma(input logic a_n, input logic b_n);
        dack_a_n = a_n;
        dack_b_n = b_n;
        cyc(3);
    endtask : dma
    task automatic hit();
        access = 1'b1;
        cyc(1);
        access = 1'b0;
    endtask : hit
endmodule : hbp_host_model

/* File: testbench/hbp_host_port_checker.sv */
`timescale 1ns/10ps
module hbp_host_port_checker
    import hbp_pkg::*;
#(parameter int N_SRC = NUM_SRC) (
    // host side
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire logic                  bus_convention_select,
    input wire logic                  access_req,
    input wire logic [N_SRC-1:0]      src_event,
    input wire logic [N_SRC-1:0]      src_ack,
    // outputs watched
    input wire logic                  conv_dir_strobe,
    input wire logic                  auxiliary_config_pin,
    input wire logic [NUM_TARGET-1:0] reg_select,
    input wire logic                  fifo_sel_valid,
    input wire logic                  irq_out,
    input wire logic                  irq_oe_n,
    input wire logic [N_SRC-1:0]      irq_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // last pending cause acknowledged, nothing new arriving
    sequence s_last_ack;
        src_ack != '0 && src_event == '0 && (irq_pending & ~src_ack) == '0;
    endsequence
    chk_irq_set: assert property (src_event != '0 |=> !irq_oe_n)
        else $error("irq not raised");
    chk_irq_clr: assert property (s_last_ack |=> irq_oe_n)
        else $error("irq not released");
    chk_irq_hold: assert property
        (irq_pending != '0 && src_ack == '0 |=> irq_pending != '0)
        else $error("pending cause lost without ack");
    chk_od_low: assert property (irq_out == 1'b0)
        else $error("irq driven high");
    chk_sel_one: assert property ($onehot0(reg_select))
        else $error("several registers selected");
    chk_sel_pulse: assert property (!access_req |=> reg_select == '0)
        else $error("select without access");
    chk_sel_hit: assert property
        (access_req |=> (reg_select != '0) ^ fifo_sel_valid)
        else $error("access missed its target");
    chk_dma_mask: assert property
        (fifo_sel_valid |-> reg_select == '0)
        else $error("register selected during dma");
    chk_aux_sep: assert property
        (!conv_dir_strobe |-> !auxiliary_config_pin)
        else $error("aux pin active in strobe mode");
    chk_conv_sel: assert property
        (bus_convention_select [*5] |-> conv_dir_strobe)
        else $error("convention strap not followed");
endmodule : hbp_host_port_checker

bind hbp_host_port hbp_host_port_checker #(.N_SRC(N_SRC)) u_chk (
    .clk(clk), .resetn(resetn), .access_req(access_req),
    .bus_convention_select(bus_convention_select),
    .src_event(src_event), .src_ack(src_ack),
    .conv_dir_strobe(conv_dir_strobe), .reg_select(reg_select),
    .auxiliary_config_pin(auxiliary_config_pin),
    .fifo_sel_valid(fifo_sel_valid), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n), .irq_pending(irq_pending)
);

/* File: testbench/tb_hbp_host_port.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    fail_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_hbp_host_port
    import hbp_pkg::*;
;
    logic clk, resetn;
    logic [NUM_SRC-1:0] src_event, src_ack;
    logic cs, st, da, db, acc, cds, aux, fv, io, ioe;
    logic [6:0] pins, ra;
    logic [NUM_TARGET-1:0] rs;
    logic [NUM_SRC-1:0] pend;
    hbp_target_t tk;
    int fail_count = 0, comparisons = 0;
    // pull-up on the shared interrupt line
    wire irq_line = ioe ? 1'b1 : io;
    hbp_host_model u_hbp_host_model (.clk(clk), .conv_sel(cs), .strobe(st),
        .pins(pins), .dack_a_n(da), .dack_b_n(db), .access(acc));
    hbp_host_port u_hbp_host_port (.clk(clk), .resetn(resetn),
        .bus_convention_select(cs), .addr_latch_strobe(st),
        .register_select_inputs(pins), .dma_ack_chan_first_n(da),
        .dma_ack_chan_second_n(db), .access_req(acc),
        .src_event(src_event), .src_ack(src_ack), .conv_dir_strobe(cds),
        .auxiliary_config_pin(aux), .reg_addr(ra), .reg_select(rs),
        .target_kind(tk), .fifo_sel_valid(fv), .irq_out(io),
        .irq_oe_n(ioe), .irq_pending(pend));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic wrap_up();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic t_reset();
        // acknowledges must not look active while the syncs refill
        repeat (2) begin
            u_hbp_host_model.cyc(1);
            `CHK(tk, TGT_REG)
        end
        u_hbp_host_model.cyc(1);
    endtask : t_reset
    task automatic t_mux();
        u_hbp_host_model.mux_latch(8'h2A);
        u_hbp_host_model.hit();
        `CHK(rs, 128'h1 << 7'h15)
        `CHK(ra, 7'h15)
        `CHK(tk, TGT_REG)
        `CHK(cds, CONV_SEP_STROBE)
    endtask : t_mux
    task automatic t_direct();
        for (int i = 0; i < 2; i++) begin
            u_hbp_host_model.direct(i[0] ? 7'h7F : 7'h00);
            u_hbp_host_model.hit();
            `CHK(rs, 128'h1 << (i[0] ? 7'h7F : 7'h00))
            `CHK(ra, (i[0] ? 7'h7F : 7'h00))
            u_hbp_host_model.cyc(1);
            `CHK(rs, 128'h0)
        end
    endtask : t_direct
    task automatic t_dma();
        hbp_target_t k[3] = '{TGT_FIFO_A, TGT_FIFO_B, TGT_FIFO_A};
        for (int i = 0; i < 3; i++) begin
            u_hbp_host_model.dma(i == 1, i == 0);
            u_hbp_host_model.hit();
            `CHK(fv, 1'b1)
            `CHK(rs, 128'h0)
            `CHK(tk, k[i])
            u_hbp_host_model.dma(1'b1, 1'b1);
        end
    endtask : t_dma
    task automatic t_dir();
        for (int s = 0; s < 2; s++) begin
            u_hbp_host_model.mode(CONV_DIR_STROBE, s[0]);
            `CHK(cds, 1'b1)
            `CHK(aux, s[0])
        end
        u_hbp_host_model.direct(7'h33);
        u_hbp_host_model.hit();
        `CHK(rs, 128'h1 << 7'h33)
        `CHK(ra, 7'h33)
        u_hbp_host_model.mode(CONV_SEP_STROBE, 1'b1);
    endtask : t_dir
    task automatic t_irq();
        src_event = 8'h08;
        u_hbp_host_model.cyc(1);
        `CHK(irq_line, 1'b0)
        src_event = 8'h20;
        u_hbp_host_model.cyc(1);
        src_event = 8'h00;
        src_ack   = 8'h08;
        `CHK(pend, 8'h28)
        u_hbp_host_model.cyc(1);
        src_ack = 8'h20;
        `CHK(irq_line, 1'b0)
        `CHK(io, 1'b0)
        u_hbp_host_model.cyc(1);
        `CHK(irq_line, 1'b1)
        // event and ack in one cycle: the event wins
        src_event = 8'h01;
        src_ack   = 8'h01;
        u_hbp_host_model.cyc(1);
        src_event = 8'h00;
        `CHK(pend, 8'h01)
        u_hbp_host_model.cyc(1);
        src_ack = 8'h00;
        `CHK(irq_line, 1'b1)
    endtask : t_irq
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial begin
        resetn    = 1'b0;
        src_event = '0;
        src_ack   = '0;
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        t_reset();
        t_mux();
        t_direct();
        t_dma();
        t_dir();
        t_irq();
        wrap_up();
    end
endmodule : tb_hbp_host_port

/* File: verilog/hbp_host_port.sv */
`timescale 1ns/10ps
// Function
// - strap low separate strobes, high direction strobe
// - latch mux address on strobe falling edge
// - strobe held high means direct address
// - decode seven address bits to one register
// - direction mode makes strobe a mode input
// - interrupt asserted while any cause pending
// - open drain interrupt, pulls low only
// - dma acknowledge selects channel fifo, ignores address
module hbp_host_port
    import hbp_pkg::*;
#(
    parameter int N_SRC = NUM_SRC
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // straps and address pins, asynchronous
    input  wire logic                  bus_convention_select,
    input  wire logic                  addr_latch_strobe,
    input  wire logic [ADDR_W-1:0]     register_select_inputs,
    // dma acknowledges, active low, asynchronous
    input  wire logic                  dma_ack_chan_first_n,
    input  wire logic                  dma_ack_chan_second_n,
    // host access strobe from the strobe decoder
    input  wire logic                  access_req,
    // interrupt causes from the channels
    input  wire logic [N_SRC-1:0]      src_event,
    input  wire logic [N_SRC-1:0]      src_ack,
    // mode outputs and decoded access target
    output logic                       conv_dir_strobe,
    output logic                       auxiliary_config_pin,
    output logic [ADDR_W-1:0]          reg_addr,
    output logic [NUM_TARGET-1:0]      reg_select,
    output hbp_target_t                target_kind,
    output logic                       fifo_sel_valid,
    // interrupt pin
    output logic                       irq_out,
    output logic                       irq_oe_n,
    output logic [N_SRC-1:0]           irq_pending
);
    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    // the select decode and the sync word assume a seven-bit address
    if (ADDR_W != 7) begin : g_bad_addr_w
        $error("hbp_host_port: address must be 7 bits");
    end
    if (N_SRC < 1 || N_SRC > 32) begin : g_bad_n_src
        $error("hbp_host_port: N_SRC must be 1 to 32");
    end

    // ------------------------------------------------------------------
    // synchroniser word layout
    // ------------------------------------------------------------------
    localparam int SW     = ADDR_W + 4;
    localparam int B_CONV = SW - 1;
    localparam int B_ALE  = SW - 2;
    localparam int B_DKA  = SW - 3;
    localparam int B_DKB  = SW - 4;
    // acknowledges reset to their idle high level, so no false dma
    // cycle shows while the flops refill after reset
    localparam logic [SW-1:0] SYNC_IDLE = {2'b00, 2'b11, ADDR_RST};

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [SW-1:0]         pin_word;
    logic [SW-1:0]         meta_ff;
    logic [SW-1:0]         sync_ff;
    logic                  ale_d_ff;
    logic [ADDR_W-1:0]     lat_ff;
    logic [ADDR_W-1:0]     out_addr_ff;
    logic [NUM_TARGET-1:0] sel_ff;
    hbp_target_t           kind_ff;
    logic                  fifo_ff;
    logic                  conv_ff;
    logic                  aux_ff;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    // every pin is asynchronous to clk, so all pass two flops
    assign pin_word = {bus_convention_select, addr_latch_strobe,
                       dma_ack_chan_first_n, dma_ack_chan_second_n,
                       register_select_inputs};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_ff <= SYNC_IDLE;
            sync_ff <= SYNC_IDLE;
        end else begin
            meta_ff <= pin_word;
            sync_ff <= meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // synchronised views
    // ------------------------------------------------------------------
    wire              s_conv  = sync_ff[B_CONV];
    wire              s_ale   = sync_ff[B_ALE];
    wire              s_dka_n = sync_ff[B_DKA];
    wire              s_dkb_n = sync_ff[B_DKB];
    wire [ADDR_W-1:0] s_addr  = sync_ff[ADDR_W-1:0];

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    wire is_sep   = (s_conv == CONV_SEP_STROBE);
    wire ale_fall = is_sep & ale_d_ff & ~s_ale;
    // strobe held high: address pins pass straight through
    wire direct   = is_sep & s_ale;
    // mux bus: address pins follow data lines wired by host
    wire [ADDR_W-1:0] cur_addr = direct ? s_addr : lat_ff;
    // direction mode has no latch, pins are the address
    wire [ADDR_W-1:0] eff_addr = is_sep ? cur_addr : s_addr;

    // ------------------------------------------------------------------
    // target decode
    // ------------------------------------------------------------------
    wire dka = ~s_dka_n;
    wire dkb = ~s_dkb_n;
    // channel one wins if both acknowledges overlap
    wire fifo_hit = dka | dkb;
    wire hbp_target_t nxt_kind = dka ? TGT_FIFO_A :
                                 dkb ? TGT_FIFO_B : TGT_REG;
    // a dma cycle ignores the address and hits no register
    wire reg_access  = access_req & ~fifo_hit;
    wire fifo_access = access_req & fifo_hit;
    wire [NUM_TARGET-1:0] nxt_sel;

    // ------------------------------------------------------------------
    // one-hot register select
    // ------------------------------------------------------------------
    // one comparator per register, so at most one select can rise
    for (genvar i = 0; i < NUM_TARGET; i++) begin : g_sel
        assign nxt_sel[i] = reg_access &
                            (eff_addr == ADDR_W'(i));
    end

    // ------------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ale_d_ff <= 1'b0;
        end else begin
            ale_d_ff <= s_ale;
        end
    end

    // capture address as strobe goes low; held through the access
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lat_ff <= ADDR_RST;
        end else if (ale_fall) begin
            lat_ff <= s_addr;
        end
    end

    // ------------------------------------------------------------------
    // access outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            out_addr_ff <= ADDR_RST;
            sel_ff      <= '0;
        end else begin
            out_addr_ff <= eff_addr;
            sel_ff      <= nxt_sel;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            kind_ff <= TGT_REG;
            fifo_ff <= 1'b0;
        end else begin
            kind_ff <= nxt_kind;
            fifo_ff <= fifo_access;
        end
    end

    // ------------------------------------------------------------------
    // mode outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            conv_ff <= CONV_SEP_STROBE;
            aux_ff  <= 1'b0;
        end else begin
            conv_ff <= s_conv;
            // strobe pin doubles as a mode level here
            aux_ff  <= ~is_sep & s_ale;
        end
    end

    // ------------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------------
    assign conv_dir_strobe      = conv_ff;
    assign auxiliary_config_pin = aux_ff;
    assign reg_addr             = out_addr_ff;
    assign reg_select           = sel_ff;
    assign target_kind          = kind_ff;
    assign fifo_sel_valid       = fifo_ff;

    // ------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------
    hbp_irq_core #(
        .N_SRC     (N_SRC)
    ) u_irq (
        .clk       (clk),
        .resetn    (resetn),
        .src_event (src_event),
        .src_ack   (src_ack),
        .irq_out   (irq_out),
        .irq_oe_n  (irq_oe_n),
        .pending   (irq_pending)
    );
endmodule : hbp_host_port

/* File: verilog/hbp_irq_core.sv */
`timescale 1ns/10ps
module hbp_irq_core
    import hbp_pkg::*;
#(
    parameter int N_SRC = NUM_SRC
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // event sources and host acknowledge
    input  wire logic [N_SRC-1:0] src_event,
    input  wire logic [N_SRC-1:0] src_ack,
    // interrupt pin, open drain
    output logic                  irq_out,
    output logic                  irq_oe_n,
    output logic [N_SRC-1:0]      pending
);
    // ------------------------------------------------------------------
    // sticky pending causes
    // ------------------------------------------------------------------
    logic [N_SRC-1:0] pend_ff;
    logic [N_SRC-1:0] nxt_pend;
    logic             any_pend;

    if (N_SRC < 1 || N_SRC > 32) begin : g_bad_n_src
        $error("hbp_irq_core: N_SRC must be 1 to 32");
    end

    // a new event in the same cycle as its ack stays pending
    assign nxt_pend = (pend_ff & ~src_ack) | src_event;
    assign any_pend = |pend_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pend_ff <= N_SRC'(PEND_RST);
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // ------------------------------------------------------------------
    // pin: only ever pulls low, enable low while driving
    // ------------------------------------------------------------------
    assign irq_out  = 1'b0;
    assign irq_oe_n = ~any_pend;
    assign pending  = pend_ff;
endmodule : hbp_irq_core

/* File: verilog/hbp_pkg.sv */
package hbp_pkg;
    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 7;
    localparam int NUM_SRC    = 8;
    localparam int NUM_TARGET = 128;
    // ------------------------------------------------------------------
    // bus convention strap levels
    // ------------------------------------------------------------------
    localparam logic CONV_SEP_STROBE = 1'b0;
    localparam logic CONV_DIR_STROBE = 1'b1;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [7:0] PEND_RST = 8'h00;
    // ------------------------------------------------------------------
    // access target kinds
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TGT_REG     = 3'b001,
        TGT_FIFO_A  = 3'b010,
        TGT_FIFO_B  = 3'b100
    } hbp_target_t;
endpackage : hbp_pkg
